// [verilog/bbx_exec.sv]
// Sequencer for bit-test branches, never-branch and memory bit-set.
// Assumes memory returns read data in the same cycle as the address.
`timescale 1ns/1ps
// Notes on behaviour
// - Clear-branch taken when operand AND mask zero
// - Set-branch taken when inverted operand AND mask zero
// - Target is op plus 4, or 5, plus offset
// - Clear-branch opcodes 13, 1F, prebyte 18 1F
// - Set-branch opcodes 12, 1E, prebyte 18 1E
// - Never-branch: three cycles, PC plus two
// - Opcode 21 is never-branch with offset byte
// - Bit-set ORs mask into memory, writes back
// - Zero mask bits leave memory bits unchanged
// - Prebyte bit-set takes mask from byte 3
// - Bit-set: N from bit 7, V cleared
// - Bit-set: Z set when result is zero
// - Bit-set opcodes 14, 1C; final cycle writes
module bbx_exec
	import bbx_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_i,
	input  wire logic        rstn_i,
	// Core bus
	output bbx_bus_t         bus_o,
	input  wire logic [7:0]  rdata_i,
	// Index registers
	input  wire logic [15:0] x_idx_i,
	input  wire logic [15:0] y_idx_i,
	// Program state
	output logic [15:0]      pc_o,
	output logic [7:0]       condition_code_reg_o,
	output logic             illegal_o
);
	typedef enum logic [3:0]
	{
		S_OPC, S_PRE, S_ADR, S_IDL1, S_RD, S_MSK, S_REL, S_IDLE_END,
		S_IDL2, S_WR, S_NREL, S_NIDLE
	} bbx_state_t;

	bbx_state_t  state_reg;
	bbx_dec_t    dec_reg;
	bbx_dec_t    dec_now;
	logic        pre_reg;
	logic [15:0] op_reg;
	logic [15:0] ea_reg;
	logic [7:0]  oper_reg;
	logic [7:0]  mask_reg;
	logic [7:0]  rel_reg;
	logic [15:0] pc_reg;
	logic [7:0]  ccr_reg;
	logic        illegal_reg;
	logic [7:0]  opc_sel;
	logic        clr_hit;
	logic        set_hit;
	logic [7:0]  result;
	logic        neg;
	logic        zero;
	logic        taken;

	function automatic logic [15:0] sext8(input logic [7:0] v);
		sext8 = {{8{v[7]}}, v};
	endfunction : sext8

	assign opc_sel = rdata_i;

	bbx_decode u_dec
	(
		.opc_i (opc_sel),
		.dec_o (dec_now)
	);

	bbx_alu u_alu
	(
		.oper_i    (oper_reg),
		.mask_i    (mask_reg),
		.clr_hit_o (clr_hit),
		.set_hit_o (set_hit),
		.result_o  (result),
		.neg_o     (neg),
		.zero_o    (zero)
	);

	assign taken = (dec_reg.kind == BBX_K_CLR) ? clr_hit : set_hit;

	// Bus address and direction per state
	always_comb
	begin
		bus_o.rd    = 1'b1;
		bus_o.wdata = 8'h00;
		case (state_reg)
			S_OPC:  bus_o.addr = pc_reg;
			S_PRE:  bus_o.addr = op_reg + ONE16;
			S_ADR:  bus_o.addr = pre_reg ? op_reg + 16'h0002
				: op_reg + ONE16;
			S_RD:   bus_o.addr = ea_reg;
			S_MSK:  bus_o.addr = pre_reg ? op_reg + 16'h0003
				: op_reg + 16'h0002;
			S_REL:  bus_o.addr = pre_reg ? op_reg + 16'h0004
				: op_reg + 16'h0003;
			S_NREL: bus_o.addr = op_reg + ONE16;
			S_WR:
			begin
				bus_o.addr  = ea_reg;
				bus_o.rd    = 1'b0;
				bus_o.wdata = result;
			end
			default: bus_o.addr = IDLE_ADDR;
		endcase
	end

	// Sequencing
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			state_reg <= S_OPC;
			pre_reg   <= 1'b0;
			dec_reg   <= '{kind: BBX_K_NONE, indexed: 1'b0};
		end
		else
		begin
			case (state_reg)
				S_OPC:
				begin
					pre_reg <= (rdata_i == OPC_PRE_Y);
					dec_reg <= dec_now;
					if (rdata_i == OPC_PRE_Y)
						state_reg <= S_PRE;
					else if (dec_now.kind == BBX_K_NEVER)
						state_reg <= S_NREL;
					else if (dec_now.kind != BBX_K_NONE)
						state_reg <= S_ADR;
				end
				S_PRE:
				begin
					dec_reg <= dec_now;
					if (dec_now.indexed && dec_now.kind != BBX_K_NEVER
						&& dec_now.kind != BBX_K_NONE)
						state_reg <= S_ADR;
					else
						state_reg <= S_OPC;
				end
				S_ADR:  state_reg <= dec_reg.indexed ? S_IDL1 : S_RD;
				S_IDL1: state_reg <= S_RD;
				S_RD:   state_reg <= S_MSK;
				S_MSK:  state_reg <= (dec_reg.kind == BBX_K_MSET)
					? S_IDL2 : S_REL;
				S_REL:  state_reg <= S_IDLE_END;
				S_IDL2: state_reg <= S_WR;
				S_NREL: state_reg <= S_NIDLE;
				default: state_reg <= S_OPC;
			endcase
		end
	end

	// Operand capture
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
		begin
			op_reg   <= PC_RESET;
			ea_reg   <= 16'h0000;
			oper_reg <= 8'h00;
			mask_reg <= 8'h00;
			rel_reg  <= 8'h00;
		end
		else
		begin
			case (state_reg)
				S_OPC: op_reg <= pc_reg;
				S_ADR:
					if (!dec_reg.indexed)
						ea_reg <= {8'h00, rdata_i};
					else if (pre_reg)
						ea_reg <= y_idx_i + {8'h00, rdata_i};
					else
						ea_reg <= x_idx_i + {8'h00, rdata_i};
				S_RD:   oper_reg <= rdata_i;
				S_MSK:  mask_reg <= rdata_i;
				S_REL:  rel_reg  <= rdata_i;
				S_NREL: rel_reg  <= rdata_i;
				default: ;
			endcase
		end
	end

	// Program counter
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			pc_reg <= PC_RESET;
		else if (state_reg == S_NIDLE)
			pc_reg <= op_reg + NEVER_LEN;
		else if (state_reg == S_IDLE_END)
		begin
			if (taken)
				pc_reg <= op_reg + (pre_reg ? BR_OFS_PRE : BR_OFS_NORM)
					+ sext8(rel_reg);
			else
				pc_reg <= op_reg + (pre_reg ? BR_OFS_PRE : BR_OFS_NORM);
		end
		else if (state_reg == S_WR)
			pc_reg <= op_reg + (pre_reg ? 16'h0004 : 16'h0003);
		else if (state_reg == S_OPC && dec_now.kind == BBX_K_NONE
			&& rdata_i != OPC_PRE_Y)
			pc_reg <= pc_reg + ONE16;
		else if (state_reg == S_PRE && state_reg != S_ADR
			&& !(dec_now.indexed && dec_now.kind != BBX_K_NEVER
			&& dec_now.kind != BBX_K_NONE))
			pc_reg <= op_reg + 16'h0002;
	end

	// Condition codes, changed only by bit-set
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			ccr_reg <= CC_RESET;
		else if (state_reg == S_WR)
		begin
			ccr_reg[CC_N] <= neg;
			ccr_reg[CC_Z] <= zero;
			ccr_reg[CC_V] <= 1'b0;
		end
	end

	// Unhandled opcode flag
	always_ff @(posedge core_clk_i)
	begin
		if (!rstn_i)
			illegal_reg <= 1'b0;
		else
			illegal_reg <= (state_reg == S_OPC && dec_now.kind == BBX_K_NONE
				&& rdata_i != OPC_PRE_Y);
	end

	assign pc_o                 = pc_reg;
	assign condition_code_reg_o = ccr_reg;
	assign illegal_o            = illegal_reg;

	a_idle_reads: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_IDL1 || state_reg == S_IDL2 || state_reg == S_IDLE_END
		|| state_reg == S_NIDLE) |-> (bus_o.rd && bus_o.addr == IDLE_ADDR))
		else $error("idle cycle not a read of FFFF");
	a_branch_flags: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_IDLE_END || state_reg == S_NIDLE)
		|=> $stable(ccr_reg))
		else $error("branch altered flags");
	a_never_len: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_OPC && rdata_i == OPC_NEVER)
		|=> ##1 state_reg == S_NIDLE ##1 (pc_reg == $past(pc_reg, 3) + 16'h0002))
		else $error("never-branch wrong length");
	a_set_write: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!bus_o.rd) |-> (bus_o.wdata == (oper_reg | mask_reg)))
		else $error("bit-set write value wrong");
	a_set_keep: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!bus_o.rd) |-> ((bus_o.wdata & ~mask_reg) == (oper_reg & ~mask_reg)))
		else $error("unmasked bit changed");
	a_set_flags: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(!bus_o.rd) |=> (ccr_reg[CC_N] == $past(bus_o.wdata[7])
		&& !ccr_reg[CC_V]
		&& ccr_reg[CC_Z] == ($past(bus_o.wdata) == 8'h00)))
		else $error("bit-set flags wrong");
	a_clr_taken: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_IDLE_END && dec_reg.kind == BBX_K_CLR
		&& (oper_reg & mask_reg) == 8'h00 && !pre_reg)
		|=> pc_reg == $past(op_reg) + 16'h0004 + sext8($past(rel_reg)))
		else $error("clear-branch target wrong");
	a_set_taken: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_IDLE_END && dec_reg.kind == BBX_K_SET
		&& (~oper_reg & mask_reg) == 8'h00 && pre_reg)
		|=> pc_reg == $past(op_reg) + 16'h0005 + sext8($past(rel_reg)))
		else $error("set-branch target wrong");
	a_clr_miss: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_IDLE_END && dec_reg.kind == BBX_K_CLR
		&& (oper_reg & mask_reg) != 8'h00)
		|=> pc_reg == $past(op_reg) + ($past(pre_reg) ? 16'h0005 : 16'h0004))
		else $error("clear-branch taken wrongly");
	a_set_miss: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_IDLE_END && dec_reg.kind == BBX_K_SET
		&& (~oper_reg & mask_reg) != 8'h00)
		|=> pc_reg == $past(op_reg) + ($past(pre_reg) ? 16'h0005 : 16'h0004))
		else $error("set-branch taken wrongly");
	a_direct_page: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_RD && !dec_reg.indexed)
		|-> (bus_o.addr == {8'h00, $past(rdata_i)}))
		else $error("direct address not zero page");
	a_index_sum: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_RD && dec_reg.indexed) |-> (bus_o.addr ==
		(pre_reg ? $past(y_idx_i, 2) : $past(x_idx_i, 2))
		+ {8'h00, $past(rdata_i, 2)}))
		else $error("indexed address wrong");
	a_never_seq: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_OPC && rdata_i == OPC_NEVER)
		|=> (bus_o.addr == $past(pc_reg) + ONE16) ##1 (bus_o.addr == IDLE_ADDR)
		##1 (state_reg == S_OPC && ccr_reg == $past(ccr_reg, 3)))
		else $error("never-branch bus order wrong");
	a_mask_pos: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_PRE && dec_now.kind == BBX_K_MSET && dec_now.indexed)
		|=> ##3 (bus_o.addr == $past(pc_reg, 4) + 16'h0003)
		##1 (mask_reg == $past(rdata_i)))
		else $error("prebyte mask fetched from wrong byte");
	a_set_wrpos: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_RD && dec_reg.kind == BBX_K_MSET)
		|=> ##2 (!bus_o.rd && bus_o.addr == $past(bus_o.addr, 3)))
		else $error("bit-set write not at operand address");
	a_illegal_skip: assert property (
		@(posedge core_clk_i) disable iff (!rstn_i)
		(state_reg == S_OPC && dec_now.kind == BBX_K_NONE
		&& rdata_i != OPC_PRE_Y)
		|=> (illegal_o && pc_reg == $past(pc_reg) + ONE16))
		else $error("unhandled opcode not skipped");
endmodule : bbx_exec

// [inc/bbx_pkg.sv]
// Package for the bit-test branch and bit-set execution block.
// Assumes a core bus with one bus cycle per core clock.
package bbx_pkg;
	localparam logic [7:0]  OPC_BRC_DIR  = 8'h13;
	localparam logic [7:0]  OPC_BRC_IDX  = 8'h1F;
	localparam logic [7:0]  OPC_BRS_DIR  = 8'h12;
	localparam logic [7:0]  OPC_BRS_IDX  = 8'h1E;
	localparam logic [7:0]  OPC_NEVER    = 8'h21;
	localparam logic [7:0]  OPC_SET_DIR  = 8'h14;
	localparam logic [7:0]  OPC_SET_IDX  = 8'h1C;
	localparam logic [7:0]  OPC_PRE_Y    = 8'h18;
	localparam logic [15:0] IDLE_ADDR    = 16'hFFFF;
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [15:0] BR_OFS_NORM  = 16'h0004;
	localparam logic [15:0] BR_OFS_PRE   = 16'h0005;
	localparam logic [15:0] NEVER_LEN    = 16'h0002;
	localparam logic [15:0] ONE16        = 16'h0001;
	localparam int          CC_N         = 3;
	localparam int          CC_Z         = 2;
	localparam int          CC_V         = 1;
	localparam logic [7:0]  CC_RESET     = 8'h00;

	typedef enum logic [2:0]
	{
		BBX_K_NONE,
		BBX_K_CLR,
		BBX_K_SET,
		BBX_K_NEVER,
		BBX_K_MSET
	} bbx_kind_t;

	typedef struct packed
	{
		logic [15:0] addr;
		logic        rd;
		logic [7:0]  wdata;
	} bbx_bus_t;

	typedef struct packed
	{
		bbx_kind_t kind;
		logic      indexed;
	} bbx_dec_t;
endpackage : bbx_pkg

// [verilog/bbx_decode.sv]
// Opcode decoder for the handled instructions.
// Assumes the opcode byte comes straight from the bus read data, uncaptured.
`timescale 1ns/1ps
module bbx_decode
	import bbx_pkg::*;
(
	// Opcode in
	input  wire logic [7:0] opc_i,
	// Decoded kind
	output bbx_dec_t        dec_o
);
	always_comb
	begin
		dec_o.indexed = 1'b0;
		case (opc_i)
			OPC_BRC_DIR: dec_o.kind = BBX_K_CLR;
			OPC_BRC_IDX:
			begin
				dec_o.kind    = BBX_K_CLR;
				dec_o.indexed = 1'b1;
			end
			OPC_BRS_DIR: dec_o.kind = BBX_K_SET;
			OPC_BRS_IDX:
			begin
				dec_o.kind    = BBX_K_SET;
				dec_o.indexed = 1'b1;
			end
			OPC_NEVER:   dec_o.kind = BBX_K_NEVER;
			OPC_SET_DIR: dec_o.kind = BBX_K_MSET;
			OPC_SET_IDX:
			begin
				dec_o.kind    = BBX_K_MSET;
				dec_o.indexed = 1'b1;
			end
			default:     dec_o.kind = BBX_K_NONE;
		endcase
	end
endmodule : bbx_decode

// [verilog/bbx_alu.sv]
// Mask test and bit-set arithmetic with flag results.
// Purely combinational; inputs come from registered operands.
`timescale 1ns/1ps
module bbx_alu
	import bbx_pkg::*;
(
	// Operands
	input  wire logic [7:0] oper_i,
	input  wire logic [7:0] mask_i,
	// Results
	output logic            clr_hit_o,
	output logic            set_hit_o,
	output logic [7:0]      result_o,
	output logic            neg_o,
	output logic            zero_o
);
	assign clr_hit_o = ((oper_i & mask_i) == 8'h00);
	assign set_hit_o = ((~oper_i & mask_i) == 8'h00);
	assign result_o  = oper_i | mask_i;
	assign neg_o     = result_o[7];
	assign zero_o    = (result_o == 8'h00);
endmodule : bbx_alu

// [tb/bbx_mem_model.sv]
// Behavioural core-bus memory for the bit-test sequencer bench.
// Assumes one bus cycle per clock, read data in the same cycle.
`timescale 1ns/1ps
module bbx_mem_model
	import bbx_pkg::*;
(
	// Clock
	input  wire logic     core_clk_i,
	// Core bus
	input  wire bbx_bus_t bus_i,
	output logic [7:0]    rdata_o
);
	logic [7:0] mem [0:65535];

	// Filler pattern, zero only where the low address byte is A5
	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem[i] = 8'(i) ^ 8'hA5;
	end

	// Data lines not driven during writes: show the inverse
	assign rdata_o = bus_i.rd ? mem[bus_i.addr] : ~mem[bus_i.addr];

	// Write lands at the end of the write cycle
	always @(posedge core_clk_i)
	begin
		if (!bus_i.rd)
			mem[bus_i.addr] <= bus_i.wdata;
	end
endmodule : bbx_mem_model

// [tb/tb_top.sv]
// Self-checking bench for the bit-test branch and bit-set sequencer.
// Assumes the memory model answers reads in the same cycle.
`timescale 1ns/1ps
module tb_top
	import bbx_pkg::*;
;
	logic        core_clk_i;
	logic        rstn_i;
	bbx_bus_t    bus;
	logic [7:0]  rdata;
	logic [15:0] x_idx;
	logic [15:0] y_idx;
	logic [15:0] pc;
	logic [7:0]  condition_code_reg;
	logic        illegal;
	int          n_errors;
	int          n_tests;
	int          cyc;

	bbx_exec u_dut
	(
		.core_clk_i           (core_clk_i),
		.rstn_i               (rstn_i),
		.bus_o                (bus),
		.rdata_i              (rdata),
		.x_idx_i              (x_idx),
		.y_idx_i              (y_idx),
		.pc_o                 (pc),
		.condition_code_reg_o (condition_code_reg),
		.illegal_o            (illegal)
	);

	bbx_mem_model u_mem
	(
		.core_clk_i (core_clk_i),
		.bus_i      (bus),
		.rdata_o    (rdata)
	);

	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic conclude;
	begin
		$display("Checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask : conclude

	// Hang guard
	always @(posedge core_clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 1000)
		begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
	begin
		n_tests++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	end
	endtask : chk

	// One instruction from reset; bit-set is followed by a never-branch
	task automatic op(input logic [7:0] opc, input logic [1:0] mode,
		input logic [7:0] oper, input logic [7:0] mask,
		input logic [7:0] rel, input logic is_set);
		logic [15:0] p;
		logic [15:0] ea;
		logic [15:0] q[$];
		logic [15:0] tgt;
		logic [7:0]  res;
		logic [7:0]  cc;
		logic        hit;
		int          w;
	begin
		w = -1;
		p = (mode == 2'd2) ? 16'h0001 : 16'h0000;
		ea = (mode == 2'd1) ? x_idx : y_idx;
		ea = (mode == 2'd0) ? 16'h00C4 : ea + 16'h00C4;
		@(posedge core_clk_i);
		#1 rstn_i = 1'b0;
		u_mem.mem[0] = OPC_PRE_Y;
		u_mem.mem[p] = opc;
		u_mem.mem[p + 1] = 8'hC4;
		u_mem.mem[p + 2] = mask;
		u_mem.mem[p + 3] = is_set ? OPC_NEVER : rel;
		u_mem.mem[p + 4] = rel;
		u_mem.mem[ea] = oper;
		if (mode == 2'd2)
			q.push_back(16'h0000);
		q.push_back(p);
		q.push_back(p + 16'h0001);
		if (mode != 2'd0)
			q.push_back(IDLE_ADDR);
		q.push_back(ea);
		q.push_back(p + 16'h0002);
		if (!is_set)
			q.push_back(p + 16'h0003);
		q.push_back(IDLE_ADDR);
		if (is_set)
		begin
			w = q.size();
			q.push_back(ea);
			q.push_back(p + 16'h0003);
			q.push_back(p + 16'h0004);
			q.push_back(IDLE_ADDR);
		end
		res = oper | mask;
		cc = is_set ? {4'h0, res[7], res == 8'h00, 2'b00} : 8'h00;
		if (opc == OPC_BRC_DIR || opc == OPC_BRC_IDX)
			hit = (oper & mask) == 8'h00;
		else
			hit = (~oper & mask) == 8'h00;
		tgt = p + 16'h0004 + ((hit && !is_set) ? {{8{rel[7]}}, rel} : 16'h0);
		tgt = is_set ? p + 16'h0005 : tgt;
		repeat (2) @(posedge core_clk_i);
		#1 rstn_i = 1'b1;
		foreach (q[i])
		begin
			@(negedge core_clk_i);
			chk("bus addr", q[i], bus.addr);
			chk("bus rd", {15'h0, i != w}, {15'h0, bus.rd});
			if (i == w)
				chk("write data", {8'h0, res}, {8'h0, bus.wdata});
		end
		@(negedge core_clk_i);
		chk("pc", tgt, pc);
		chk("flags", {8'h0, cc}, {8'h0, condition_code_reg});
		if (is_set)
			chk("memory", {8'h0, res}, {8'h0, u_mem.mem[ea]});
	end
	endtask : op

	// Unknown opcode, refused prebyte pair, then a never-branch
	task automatic refuse;
		logic [15:0] a[6];
		logic        ill[6];
	begin
		a = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004, IDLE_ADDR};
		ill = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
		@(posedge core_clk_i);
		#1 rstn_i = 1'b0;
		u_mem.mem[0] = 8'h00;
		u_mem.mem[1] = OPC_PRE_Y;
		u_mem.mem[2] = OPC_BRC_DIR;
		u_mem.mem[3] = OPC_NEVER;
		u_mem.mem[4] = 8'h80;
		repeat (2) @(posedge core_clk_i);
		#1 rstn_i = 1'b1;
		for (int i = 0; i < 6; i++)
		begin
			@(negedge core_clk_i);
			chk("bus addr", a[i], bus.addr);
			chk("illegal", {15'h0, ill[i]}, {15'h0, illegal});
		end
		@(negedge core_clk_i);
		chk("pc", 16'h0005, pc);
		chk("flags", 16'h0000, {8'h0, condition_code_reg});
	end
	endtask : refuse

	initial
	begin
		rstn_i = 1'b0;
		x_idx = 16'h1F70;
		y_idx = 16'h2000;
		n_errors = 0;
		n_tests = 0;
		cyc = 0;
		op(OPC_BRC_DIR, 2'd0, 8'hF0, 8'h0F, 8'h10, 1'b0);
		op(OPC_BRC_IDX, 2'd1, 8'h01, 8'h01, 8'h20, 1'b0);
		op(OPC_BRC_IDX, 2'd2, 8'h00, 8'hFF, 8'hF0, 1'b0);
		op(OPC_BRS_DIR, 2'd0, 8'h80, 8'h81, 8'h10, 1'b0);
		op(OPC_BRS_IDX, 2'd1, 8'hFF, 8'h81, 8'h7F, 1'b0);
		op(OPC_BRS_IDX, 2'd2, 8'h83, 8'h81, 8'hFC, 1'b0);
		op(OPC_SET_DIR, 2'd0, 8'h05, 8'h80, 8'h00, 1'b1);
		op(OPC_SET_IDX, 2'd1, 8'h00, 8'h00, 8'h00, 1'b1);
		op(OPC_SET_IDX, 2'd2, 8'h5A, 8'h21, 8'h00, 1'b1);
		refuse();
		conclude();
	end
endmodule : tb_top
